// ==== rtl/ring_sine_pwm_controller.sv ====
// Sine ring PWM controller core with tracking A/D, protection and APB registers
`default_nettype none
module ring_sine_pwm_controller
  import ring_pwm_pkg::*;
#(
  parameter int OVL_PULSE_THRESHOLD = OVL_THRESHOLD,
  parameter int OVL_TIMER_CNT       = OVL_TIMER_CYCLES,
  parameter int SHUTDOWN_CNT        = SHUTDOWN_CYCLES,
  parameter int STEP_CNT_50         = STEP_DIV_50,
  parameter int STEP_CNT_167        = STEP_DIV_167,
  parameter int STEP_CNT_25         = STEP_DIV_25,
  parameter int STEP_CNT_20         = STEP_DIV_20
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        output_disable_in,
  input  wire logic        pwm_rate_select,
  input  wire logic        ring_freq_sel_bit0,
  input  wire logic        ring_freq_sel_bit1,
  input  wire logic        adc_compare_in,
  input  wire logic        current_limit_n,
  output var  logic        drive_pwm_out,
  output var  logic        adc_dac_pwm_out,
  output var  logic        overload_flag
);
  localparam int TMR_W = 26;
  localparam int ADC_DIV_W = $clog2(ADC_SAMPLE_DIV);

  // Pin synchronisation
  logic [5:0] pin_s;
  wire        inhibit_s = pin_s[5];
  wire        rate_s    = pin_s[4];
  wire [1:0]  freq_s    = pin_s[3:2];
  wire        cmp_s     = pin_s[1];
  wire        cl_low    = ~pin_s[0];

  pin_sync #(
    .WIDTH (6)
  ) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({output_disable_in, pwm_rate_select, ring_freq_sel_bit1, ring_freq_sel_bit0,
               adc_compare_in, current_limit_n}),
    .q       (pin_s)
  );

  // Pin-driven reset
  logic [3:0] rst_cnt_q;
  logic       soft_rst_q;
  wire        rst_cond = inhibit_s & rate_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt_q  <= 4'h0;
      soft_rst_q <= 1'b0;
    end else if (!rst_cond) begin
      rst_cnt_q  <= 4'h0;
      soft_rst_q <= 1'b0;
    end else if (rst_cnt_q == RESET_LAST) begin
      soft_rst_q <= 1'b1;
    end else begin
      rst_cnt_q  <= rst_cnt_q + 4'h1;
    end
  end

  // Frequency strap, caught after reset release and after a pin reset
  logic [1:0] freq_q;
  logic [1:0] strap_wait_q;
  wire        strap_open = (strap_wait_q != 2'h3) | soft_rst_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_q       <= 2'h0;
      strap_wait_q <= 2'h0;
    end else begin
      if (strap_open) begin
        freq_q <= freq_s;
      end
      strap_wait_q <= soft_rst_q ? 2'h0 : (strap_open ? strap_wait_q + 2'h1 : strap_wait_q);
    end
  end

  // Sine table stepping
  logic [15:0] sine_div_q;
  logic [4:0]  idx_q;
  logic [7:0]  sine_val;
  wire  [15:0] step_div = (freq_q == 2'b00) ? 16'(STEP_CNT_50 - 1) :
                          (freq_q == 2'b01) ? 16'(STEP_CNT_167 - 1) :
                          (freq_q == 2'b10) ? 16'(STEP_CNT_25 - 1) :
                                              16'(STEP_CNT_20 - 1);
  wire         tick     = (sine_div_q >= step_div);
  wire         half_end = tick & (idx_q == IDX_LAST);
  wire         peak     = tick & (idx_q == IDX_PEAK);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sine_div_q <= 16'h0;
      idx_q      <= 5'h0;
    end else if (soft_rst_q) begin
      sine_div_q <= 16'h0;
      idx_q      <= 5'h0;
    end else begin
      sine_div_q <= tick ? 16'h0 : sine_div_q + 16'h1;
      idx_q      <= tick ? idx_q + 5'h1 : idx_q;
    end
  end

  half_sine_lut u_half_sine_lut (
    .idx (idx_q),
    .val (sine_val)
  );

  // Tracking A/D
  logic [ADC_DIV_W-1:0] adc_div_q;
  logic [7:0] adc_q;
  logic [7:0] reg_adc_q;
  logic [2:0] adc_phase_q;
  logic [4:0] adc_acc_q;
  logic [3:0] adc_hi_q;
  wire        adc_sample = (adc_div_q == ADC_DIV_W'(ADC_SAMPLE_DIV - 1));
  wire        adc_frame  = (adc_phase_q == ADC_PHASE_LAST);
  wire [5:0]  acc_sum    = {1'b0, adc_acc_q} + {1'b0, adc_q[4:0]};
  wire [8:0]  adc_ext    = {1'b0, adc_q};
  wire [8:0]  reg_ext    = {1'b0, reg_adc_q};
  wire        adc_moved  = (adc_ext > reg_ext + 9'h001) | (reg_ext > adc_ext + 9'h001);
  wire [7:0]  adc_up     = (adc_q != 8'hff) ? adc_q + 8'h01 : adc_q;
  wire [7:0]  adc_down   = (adc_q != 8'h00) ? adc_q - 8'h01 : adc_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_div_q   <= '0;
      adc_q       <= 8'h00;
      reg_adc_q   <= 8'h00;
      adc_phase_q <= 3'h0;
      adc_acc_q   <= 5'h00;
      adc_hi_q    <= 4'h0;
    end else if (soft_rst_q) begin
      adc_div_q   <= '0;
      adc_q       <= 8'h00;
      reg_adc_q   <= 8'h00;
      adc_phase_q <= 3'h0;
      adc_acc_q   <= 5'h00;
      adc_hi_q    <= 4'h0;
    end else begin
      adc_div_q   <= adc_div_q + ADC_DIV_W'(1);
      adc_phase_q <= adc_phase_q + 3'h1;
      if (adc_sample) begin
        adc_q <= cmp_s ? adc_up : adc_down;
      end
      if (peak && adc_moved) begin
        reg_adc_q <= adc_q;
      end
      if (adc_frame) begin
        adc_acc_q <= acc_sum[4:0];
        adc_hi_q  <= {1'b0, adc_q[7:5]} + {3'h0, acc_sum[5]};
      end
    end
  end

  // Duty calculation
  logic [4:0]  step_q;
  logic [6:0]  pwm_cnt_q;
  logic [6:0]  duty_q;
  wire  [8:0]  corr      = (reg_adc_q == 8'h00) ? CORR_UNITY : CORR_FULL - reg_ext;
  wire  [16:0] prod      = {9'h000, sine_val} * {8'h00, corr};
  wire  [16:0] duty_raw  = prod / {9'h000, step_q, 3'b000};
  wire  [6:0]  duty_sat  = (duty_raw[16:1] > {9'h000, DUTY_MAX_LO}) ? DUTY_MAX_LO : duty_raw[7:1];
  wire  [6:0]  duty_eff  = rate_s ? {1'b0, duty_sat[6:1]} : duty_sat;
  wire  [6:0]  pwm_last  = rate_s ? PWM_LAST_HI : PWM_LAST_LO;
  wire         pwm_start = (pwm_cnt_q >= pwm_last);

  // Current limit
  logic cutoff_q;
  logic cl_low_prev_q;
  logic [7:0] pulse_cnt_q;
  wire  cl_fall   = cl_low & ~cl_low_prev_q;
  wire  cutoff_d  = cl_low | (cutoff_q & ~pwm_start);
  wire  over_half = (pulse_cnt_q > 8'(OVL_PULSE_THRESHOLD));
  wire  none_half = (pulse_cnt_q == 8'h00);
  wire [7:0] pulse_inc = (pulse_cnt_q != 8'hff) ? pulse_cnt_q + 8'h01 : pulse_cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_cnt_q     <= 7'h00;
      duty_q        <= 7'h00;
      cutoff_q      <= 1'b0;
      cl_low_prev_q <= 1'b0;
      pulse_cnt_q   <= 8'h00;
    end else begin
      pwm_cnt_q     <= pwm_start ? 7'h00 : pwm_cnt_q + 7'h01;
      duty_q        <= pwm_start ? duty_eff : duty_q;
      cutoff_q      <= cutoff_d;
      cl_low_prev_q <= cl_low;
      if (soft_rst_q) begin
        pulse_cnt_q <= 8'h00;
      end else if (half_end) begin
        pulse_cnt_q <= cl_fall ? 8'h01 : 8'h00;
      end else if (cl_fall) begin
        pulse_cnt_q <= pulse_inc;
      end
    end
  end

  // Protection state machine and amplitude step
  prot_state_type prot_q;
  prot_state_type prot_d;
  logic [TMR_W-1:0] tmr_q;
  logic [1:0] hold_q;
  logic       over_last_q;
  wire        ovl_expired  = (tmr_q == TMR_W'(OVL_TIMER_CNT - 1));
  wire        shut_expired = (tmr_q == TMR_W'(SHUTDOWN_CNT - 1));
  wire        at_min       = (step_q == STEP_MAX);

  always_comb begin
    prot_d = prot_q;
    case (prot_q)
      PROT_RUN: begin
        if (half_end && at_min && over_half) begin
          prot_d = PROT_TIMING;
        end
      end
      PROT_TIMING: begin
        if (!at_min) begin
          prot_d = PROT_RUN;
        end else if (ovl_expired) begin
          prot_d = over_last_q ? PROT_SHUT : PROT_RUN;
        end
      end
      PROT_SHUT: begin
        if (shut_expired) begin
          prot_d = PROT_RUN;
        end
      end
      default: prot_d = PROT_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_q <= PROT_RUN;
      tmr_q  <= '0;
    end else if (soft_rst_q) begin
      prot_q <= PROT_RUN;
      tmr_q  <= '0;
    end else begin
      prot_q <= prot_d;
      tmr_q  <= (prot_d != prot_q) ? '0 : tmr_q + TMR_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_q      <= STEP_NOMINAL;
      hold_q      <= 2'h0;
      over_last_q <= 1'b0;
    end else if (soft_rst_q) begin
      step_q      <= STEP_NOMINAL;
      hold_q      <= 2'h0;
      over_last_q <= 1'b0;
    end else if (prot_q == PROT_SHUT) begin
      step_q      <= STEP_MAX;
      over_last_q <= 1'b0;
    end else if (half_end) begin
      over_last_q <= over_half;
      if (over_half && !at_min) begin
        step_q <= step_q + 5'h01;
      end else if (none_half && step_q != STEP_NOMINAL) begin
        step_q <= step_q - 5'h01;
      end
      if (none_half && step_q == STEP_NOMINAL + 5'h01) begin
        hold_q <= FLAG_HOLD_HALVES;
      end else if (over_half) begin
        hold_q <= 2'h0;
      end else if (step_q == STEP_NOMINAL && hold_q != 2'h0) begin
        hold_q <= hold_q - 2'h1;
      end
    end
  end

  // Inhibit handling and drive output
  logic ctrl_sw_disable_q;
  logic out_en_q;
  wire  drive_d = out_en_q & ~ctrl_sw_disable_q & (prot_q != PROT_SHUT) & ~cutoff_d & (pwm_cnt_q < duty_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_en_q      <= 1'b0;
      drive_pwm_out <= 1'b0;
      overload_flag <= 1'b0;
    end else begin
      if (soft_rst_q) begin
        out_en_q <= 1'b0;
      end else if (inhibit_s && (rate_s || half_end)) begin
        out_en_q <= 1'b0;
      end else if (!inhibit_s && half_end) begin
        out_en_q <= 1'b1;
      end
      drive_pwm_out <= drive_d;
      overload_flag <= (step_q > STEP_NOMINAL) | (hold_q != 2'h0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_dac_pwm_out <= 1'b0;
    end else begin
      adc_dac_pwm_out <= ({1'b0, adc_phase_q} < adc_hi_q);
    end
  end

  // APB slave, one wait state
  prot_status_type status;
  logic [31:0] ctrl_q;
  wire         apb_access = psel & penable & ~pready;
  wire         apb_commit = psel & penable & pready;
  wire         hit_ctrl   = (paddr == CTRL_OFFSET);
  wire         hit_status = (paddr == STATUS_OFFSET);
  wire         hit_adc    = (paddr == ADC_OFFSET);
  wire         hit_any    = hit_ctrl | hit_status | hit_adc;
  wire [31:0]  rd_mux     = hit_ctrl   ? ctrl_q :
                            hit_status ? {23'h0, status} :
                            hit_adc    ? {16'h0, adc_q, reg_adc_q} : 32'h0;

  assign status = '{out_enabled: out_en_q, timing: (prot_q == PROT_TIMING),
                    shutdown: (prot_q == PROT_SHUT), overload: overload_flag, step: step_q};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      ctrl_q  <= CTRL_RESET;
    end else begin
      pready  <= apb_access;
      pslverr <= apb_access & ~hit_any;
      prdata  <= (apb_access && !pwrite) ? rd_mux : 32'h0;
      if (apb_commit && pwrite && hit_ctrl) begin
        ctrl_q <= {31'h0, pwdata[CTRL_SW_DISABLE_BIT]};
      end
    end
  end

  assign ctrl_sw_disable_q = ctrl_q[CTRL_SW_DISABLE_BIT];
endmodule
`default_nettype wire

// ==== rtl/ring_pwm_pkg.sv ====
// Shared constants and types for the sine ring PWM controller
`default_nettype none
package ring_pwm_pkg;
  localparam int CLK_HZ        = 10_000_000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESET_MIN_NS  = 1000;
  localparam int RESET_CYCLES  = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam logic [3:0] RESET_LAST = 4'(RESET_CYCLES - 1);

  localparam int FREQ_50_DHZ  = 500;
  localparam int FREQ_167_DHZ = 167;
  localparam int FREQ_25_DHZ  = 250;
  localparam int FREQ_20_DHZ  = 200;
  localparam int TABLE_POINTS = 32;
  localparam int STEP_DIV_50  = CLK_HZ / (2 * FREQ_50_DHZ * TABLE_POINTS) * 10;
  localparam int STEP_DIV_167 = CLK_HZ / (2 * FREQ_167_DHZ * TABLE_POINTS) * 10;
  localparam int STEP_DIV_25  = CLK_HZ / (2 * FREQ_25_DHZ * TABLE_POINTS) * 10;
  localparam int STEP_DIV_20  = CLK_HZ / (2 * FREQ_20_DHZ * TABLE_POINTS) * 10;
  localparam logic [4:0] IDX_PEAK = 5'h0f;
  localparam logic [4:0] IDX_LAST = 5'h1f;

  localparam int OVL_TIMER_MS     = 300;
  localparam int OVL_TIMER_CYCLES = OVL_TIMER_MS * (CLK_HZ / 1000);
  localparam int SHUTDOWN_MS      = 4860;
  localparam int SHUTDOWN_CYCLES  = SHUTDOWN_MS * (CLK_HZ / 1000);

  localparam logic [6:0] PWM_LAST_LO = 7'h7f;
  localparam logic [6:0] PWM_LAST_HI = 7'h3f;
  localparam logic [6:0] DUTY_MAX_LO = 7'h76;
  localparam logic [2:0] ADC_PHASE_LAST = 3'h7;
  localparam int ADC_SAMPLE_DIV = 2048;
  localparam logic [8:0] CORR_UNITY = 9'h080;
  localparam logic [8:0] CORR_FULL  = 9'h100;

  localparam logic [4:0] STEP_NOMINAL = 5'h10;
  localparam logic [4:0] STEP_MAX     = 5'h1f;
  localparam logic [1:0] FLAG_HOLD_HALVES = 2'h2;
  localparam int OVL_THRESHOLD = 4;

  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] ADC_OFFSET    = 12'h008;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam int CTRL_SW_DISABLE_BIT = 0;

  typedef struct packed {
    logic       out_enabled;
    logic       timing;
    logic       shutdown;
    logic       overload;
    logic [4:0] step;
  } prot_status_type;

  typedef enum logic [1:0] {PROT_RUN, PROT_TIMING, PROT_SHUT} prot_state_type;
endpackage
`default_nettype wire

// ==== rtl/pin_sync.sv ====
// Two flip-flop synchroniser for a group of pin inputs
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/half_sine_lut.sv ====
// Half sine table, 32 points, mirrored from one quarter
`default_nettype none
module half_sine_lut (
  input  wire logic [4:0] idx,
  output var  logic [7:0] val
);
  logic [3:0] q_idx;

  assign q_idx = idx[4] ? ~idx[3:0] : idx[3:0];

  always_comb begin
    case (q_idx)
      4'h0:    val = 8'h0c;
      4'h1:    val = 8'h25;
      4'h2:    val = 8'h3e;
      4'h3:    val = 8'h56;
      4'h4:    val = 8'h6d;
      4'h5:    val = 8'h83;
      4'h6:    val = 8'h98;
      4'h7:    val = 8'hab;
      4'h8:    val = 8'hbd;
      4'h9:    val = 8'hcd;
      4'ha:    val = 8'hdb;
      4'hb:    val = 8'he7;
      4'hc:    val = 8'hf0;
      4'hd:    val = 8'hf7;
      4'he:    val = 8'hfc;
      default: val = 8'hff;
    endcase
  end
endmodule
`default_nettype wire

// ==== test/ring_pwm_properties.sv ====
// Port-level assertions for the sine ring PWM controller
`default_nettype none
module ring_pwm_properties #(
  parameter int STEP_CNT_50  = 4,
  parameter int STEP_CNT_167 = 4,
  parameter int STEP_CNT_25  = 4,
  parameter int STEP_CNT_20  = 4
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        output_disable_in,
  input wire logic        pwm_rate_select,
  input wire logic        current_limit_n,
  input wire logic        drive_pwm_out,
  input wire logic        adc_dac_pwm_out,
  input wire logic        overload_flag
);
  localparam int MIN_A    = (STEP_CNT_50 < STEP_CNT_167) ? STEP_CNT_50 : STEP_CNT_167;
  localparam int MIN_B    = (STEP_CNT_25 < STEP_CNT_20) ? STEP_CNT_25 : STEP_CNT_20;
  localparam int FLAG_MIN = 64 * ((MIN_A < MIN_B) ? MIN_A : MIN_B);
  logic [31:0] flag_len_q;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Length of the current overload flag pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_len_q <= 32'h0;
    end else begin
      flag_len_q <= overload_flag ? flag_len_q + 32'h1 : 32'h0;
    end
  end

  a_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("access not completed after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside completion");
  a_cl_cutoff: assert property ($fell(current_limit_n) |-> ##[1:3] !drive_pwm_out)
    else $error("drive not cut after current limit");
  a_inhibit_now: assert property ((output_disable_in && pwm_rate_select) [*6] |-> !drive_pwm_out)
    else $error("drive active under inhibit at high rate");
  a_adc_spacing: assert property ($rose(adc_dac_pwm_out) |=> (!$rose(adc_dac_pwm_out)) [*7])
    else $error("A/D pulses closer than eight clocks");
  a_flag_hold: assert property ($fell(overload_flag) |-> flag_len_q >= FLAG_MIN)
    else $error("overload flag pulse too short");

  c_unmapped: cover property (pslverr);
  c_overload: cover property ($rose(overload_flag));
  c_cutoff: cover property ($fell(current_limit_n));
endmodule
`default_nettype wire

// ==== test/flyback_stage_model.sv ====
// Flyback stage, current sense and A/D comparator model
`default_nettype none
module flyback_stage_model #(
  parameter logic [7:0] VSAMPLE = 8'hc0
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic drive_pwm_out,
  input  wire logic adc_dac_pwm_out,
  input  wire logic overload_en,
  input  wire logic comp_en,
  output var  logic current_limit_n,
  output var  logic adc_compare_in
);
  logic [7:0] hist_q;
  logic [8:0] dc_level;

  // Low pass stand-in: share of high bits over the last eight clocks
  assign dc_level = 9'($countones(hist_q)) << 5;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_q          <= 8'h00;
      current_limit_n <= 1'b1;
      adc_compare_in  <= 1'b0;
    end else begin
      hist_q <= {hist_q[6:0], adc_dac_pwm_out};
      // Sense trips while the switch conducts in overload, clears once it opens
      current_limit_n <= !(overload_en && drive_pwm_out);
      // Comparator output held at ground while the A/D is unused
      adc_compare_in <= comp_en && ({1'b0, VSAMPLE} > dc_level);
    end
  end
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the sine ring PWM controller
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ring_pwm_pkg::*;
  logic        pclk              = 1'b0;
  logic        presetn           = 1'b0;
  logic [11:0] paddr             = 12'h000;
  logic        psel              = 1'b0;
  logic        penable           = 1'b0;
  logic        pwrite            = 1'b0;
  logic [31:0] pwdata            = 32'h0;
  logic        output_disable_in = 1'b1;
  logic        pwm_rate_select   = 1'b1;
  logic        freq_b0           = 1'b0;
  logic        freq_b1           = 1'b0;
  logic        overload_en       = 1'b0;
  logic        comp_en           = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rd;
  logic        err;
  wire logic   adc_compare_in;
  wire logic   current_limit_n;
  wire logic   drive_pwm_out;
  wire logic   adc_dac_pwm_out;
  wire logic   overload_flag;
  int          num_errors        = 0;
  int          n_compared        = 0;
  // Table step periods per select code, kept in inverse ratio to the four ring frequencies
  localparam int HALF_50  = 40;
  localparam int HALF_167 = 120;
  localparam int HALF_25  = 80;
  localparam int HALF_20  = 100;

  always #50 pclk = ~pclk;

  ring_sine_pwm_controller #(.OVL_TIMER_CNT(200), .SHUTDOWN_CNT(300), .STEP_CNT_50(HALF_50),
    .STEP_CNT_167(HALF_167), .STEP_CNT_25(HALF_25), .STEP_CNT_20(HALF_20)) ring_sine_pwm_controller_i (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .output_disable_in, .pwm_rate_select, .ring_freq_sel_bit0(freq_b0), .ring_freq_sel_bit1(freq_b1),
    .adc_compare_in, .current_limit_n, .drive_pwm_out, .adc_dac_pwm_out, .overload_flag);

  flyback_stage_model flyback_stage_model_i (.pclk, .presetn, .drive_pwm_out, .adc_dac_pwm_out,
    .overload_en, .comp_en, .current_limit_n, .adc_compare_in);

  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      num_errors++;
      finish_test();
    end
  endtask

  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int n;
    for (n = 0; n < 20000; n++) begin
      apb(STATUS_OFFSET, 1'b0, 32'h0);
      if ((rd & m) === v) break;
    end
    check("status poll", v, rd & m);
    if (n == 20000) begin
      finish_test();
    end
  endtask

  // Pin reset with new frequency straps, then time the first half cycle after release
  task automatic half_cycle(input logic [1:0] f, input int n);
    int  k;
    time t0;
    output_disable_in <= 1'b1;
    pwm_rate_select   <= 1'b1;
    repeat (16) @(posedge pclk);
    freq_b0           <= f[0];
    freq_b1           <= f[1];
    repeat (4) @(posedge pclk);
    output_disable_in <= 1'b0;
    pwm_rate_select   <= 1'b0;
    t0 = $time;
    rd = 32'h0;
    for (k = 0; k < 2000 && rd[8] !== 1'b1; k++) begin
      apb(STATUS_OFFSET, 1'b0, 32'h0);
    end
    check("half cycle table steps", 32'(n), 32'((($time - t0) / CLK_PERIOD_NS - 4) / 32));
    if (k == 2000) begin
      finish_test();
    end
  endtask

  initial begin
    repeat (99000) @(posedge pclk);
    num_errors++;
    finish_test();
  end

  task automatic stays_low(input int c);
    int hi;
    hi = 0;
    repeat (c) begin
      @(posedge pclk);
      if (drive_pwm_out !== 1'b0) hi++;
    end
    check("drive high count", 32'h0, hi);
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (20) @(posedge pclk);
    output_disable_in <= 1'b0;
    pwm_rate_select   <= 1'b0;
    apb(CTRL_OFFSET, 1'b0, 32'h0);
    check("ctrl reset", CTRL_RESET, rd);
    apb(STATUS_OFFSET, 1'b1, 32'hff);
    apb(STATUS_OFFSET, 1'b0, 32'h0);
    check("nominal step", 32'h10, rd & 32'h7f);
    apb(12'h00c, 1'b0, 32'h0);
    check("unmapped err", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, rd);
    repeat (2100) @(posedge pclk);
    apb(ADC_OFFSET, 1'b0, 32'h0);
    check("adc unused", 32'h0, rd & 32'hffff);
    comp_en <= 1'b1;
    poll(32'h100, 32'h100);
    apb(CTRL_OFFSET, 1'b1, 32'h1);
    apb(CTRL_OFFSET, 1'b0, 32'h0);
    check("ctrl", 32'h1, rd);
    stays_low(300);
    apb(CTRL_OFFSET, 1'b1, 32'h0);
    output_disable_in <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(STATUS_OFFSET, 1'b0, 32'h0);
    check("enabled until half end", 32'h100, rd & 32'h100);
    poll(32'h100, 32'h0);
    output_disable_in <= 1'b0;
    poll(32'h100, 32'h100);
    overload_en <= 1'b1;
    poll(32'h3f, 32'h3f);
    check("overload pin", 32'h1, {31'h0, overload_flag});
    poll(32'h40, 32'h40);
    stays_low(200);
    overload_en <= 1'b0;
    poll(32'h7f, 32'h10);
    check("overload pin clear", 32'h0, {31'h0, overload_flag});
    apb(ADC_OFFSET, 1'b0, 32'h0);
    check("adc tracked", 32'h1, {31'h0, rd[15:8] != 8'h00});
    output_disable_in <= 1'b1;
    pwm_rate_select   <= 1'b1;
    repeat (20) @(posedge pclk);
    apb(ADC_OFFSET, 1'b0, 32'h0);
    check("adc after pin reset", 32'h0, rd & 32'hffff);
    half_cycle(2'b01, HALF_167);
    half_cycle(2'b10, HALF_25);
    half_cycle(2'b11, HALF_20);
    half_cycle(2'b00, HALF_50);
    finish_test();
  end
endmodule

bind ring_sine_pwm_controller ring_pwm_properties #(.STEP_CNT_50(STEP_CNT_50), .STEP_CNT_167(STEP_CNT_167),
  .STEP_CNT_25(STEP_CNT_25), .STEP_CNT_20(STEP_CNT_20)) ring_pwm_properties_i (.pclk, .presetn, .psel,
  .penable, .prdata, .pready, .pslverr, .output_disable_in, .pwm_rate_select, .current_limit_n,
  .drive_pwm_out, .adc_dac_pwm_out, .overload_flag);
`default_nettype wire
